/* File: logic/mcmc_pkg.sv */
package mcmc_pkg;
   // register byte addresses
   localparam logic [31:0] LOOP_CONTROL_ADDR = 32'h029a0100;
   localparam logic [31:0] LOOP_MULTIPLIER_ADDR = 32'h029a0110;
   localparam logic [31:0] INPUT_PRE_DIVIDER_ADDR = 32'h029a0114;

   // loop_control field positions
   localparam int CTL_MODE_BIT = 0;
   localparam int CTL_PWRDN_BIT = 1;
   localparam int CTL_RSV2_BIT = 2;
   localparam int CTL_RESET_BIT = 3;
   localparam int CTL_RSV54_LO = 4;
   localparam int CTL_RSV6_BIT = 6;
   localparam int CTL_RSV7_BIT = 7;

   // loop_multiplier and input_pre_divider field positions
   localparam int MULT_LO = 0;
   localparam int MULT_W = 5;
   localparam int PRE_RATIO_LO = 0;
   localparam int PRE_RATIO_W = 5;
   localparam int PRE_EN_BIT = 15;

   // values after reset
   localparam logic RST_MODE = 1'b0;
   localparam logic RST_PWRDN = 1'b0;
   localparam logic RST_LOOP_RESET = 1'b1;
   localparam logic RST_PRE_EN = 1'b1;
   localparam logic [4:0] RST_PRE_RATIO = 5'h02;
   localparam logic [4:0] RST_MULT = 5'h00;
   localparam logic RSV6_VALUE = 1'b1;
   localparam logic RST_RSV7 = 1'b0;
   localparam logic [1:0] RST_RSV54 = 2'h0;
   localparam logic [5:0] RST_FACTOR = 6'h01;
   localparam logic [5:0] RST_DIVISOR = 6'h03;

   // software wait figures, in ns per input period and in core cycles
   localparam int CORE_PERIOD_NS = 40;
   localparam int RESET_TIME_PERIODS = 128;
   localparam int LOCK_TIME_PERIODS = 2000;
   localparam int RESET_TIME_NS = RESET_TIME_PERIODS * CORE_PERIOD_NS;
   localparam int LOCK_TIME_NS = LOCK_TIME_PERIODS * CORE_PERIOD_NS;
   localparam int RESET_TIME_CYC =
      (RESET_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int LOCK_TIME_CYC = LOCK_TIME_NS / CORE_PERIOD_NS;

   // encoded field to divide or multiply factor: value plus one
   function automatic logic [5:0] mcmc_plus_one(input logic [4:0] v);
      mcmc_plus_one = {1'b0, v} + 6'h01;
   endfunction : mcmc_plus_one
endpackage : mcmc_pkg

/* File: logic/mcmc_steer_if.sv */
`timescale 1ns/1ps
interface mcmc_steer_if;
   logic mode;
   logic [4:0] mult;
   logic pre_en;
   logic [4:0] pre_ratio;
   logic src_loop;
   logic [5:0] factor;
   logic [5:0] divisor;
   logic pre_out_en;

   modport ctrl (
      output mode,
      output mult,
      output pre_en,
      output pre_ratio,
      input src_loop,
      input factor,
      input divisor,
      input pre_out_en
   );
   modport steer (
      input mode,
      input mult,
      input pre_en,
      input pre_ratio,
      output src_loop,
      output factor,
      output divisor,
      output pre_out_en
   );
endinterface : mcmc_steer_if

/* File: logic/mcmc_steer.sv */
`timescale 1ns/1ps
module mcmc_steer (
   input wire logic clk,
   input wire logic rst,
   mcmc_steer_if.steer st
);
   logic src_loop_q, src_loop_d;
   logic [5:0] factor_q, factor_d;
   logic [5:0] divisor_q, divisor_d;
   logic pre_en_q, pre_en_d;

   // settings only reach the reference path while multiply mode is on
   always_comb begin
      src_loop_d = st.mode; // R8 R9
      factor_d = factor_q;
      divisor_d = divisor_q;
      pre_en_d = pre_en_q;
      if (st.mode) begin // R17
         factor_d = mcmc_pkg::mcmc_plus_one(st.mult); // R10 R11
         divisor_d = mcmc_pkg::mcmc_plus_one(st.pre_ratio); // R10 R13
         pre_en_d = st.pre_en; // R12
      end
   end

   // applied settings register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_loop_q <= mcmc_pkg::RST_MODE;
         factor_q <= mcmc_pkg::RST_FACTOR;
         divisor_q <= mcmc_pkg::RST_DIVISOR;
         pre_en_q <= mcmc_pkg::RST_PRE_EN;
      end else begin
         src_loop_q <= src_loop_d;
         factor_q <= factor_d;
         divisor_q <= divisor_d;
         pre_en_q <= pre_en_d;
      end
   end

   assign st.src_loop = src_loop_q;
   assign st.factor = factor_q;
   assign st.divisor = divisor_q;
   assign st.pre_out_en = pre_en_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_bypass_source: assert property (!st.mode |=> !st.src_loop) // R8
      else $error("bypass did not select input reference");
   a_loop_factor: assert property (st.mode |=> // R11
      st.factor == {1'b0, $past(st.mult)} + 6'h01)
      else $error("multiply factor not field plus one");
   a_bypass_hold: assert property (!st.mode |=> $stable(st.factor) // R17
      && $stable(st.divisor) && $stable(st.pre_out_en))
      else $error("applied setting moved during bypass");
   c_enter_loop: cover property (!st.mode ##1 st.mode ##1 st.src_loop);
endmodule : mcmc_steer

/* File: logic/mcmc_control.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - Only the core port and the emulator port can reach the registers.
// R2 - Software never writes unlisted addresses nor changes reserved bits.
// R3 - Read-only reserved fields read zero and ignore writes.
// R4 - Control bit 6 always reads one and ignores writes.
// R5 - Software keeps control bits 7 and 5:4 at zero on every write.
// R6 - Control bit 3 holds the loop in reset, read/write, reset value one.
// R7 - Control bit 1 powers down the loop analog parts, reset value zero.
// R8 - Control bit 0 at zero, its reset value, bypasses pre-divider and loop.
// R9 - Control bit 0 at one routes through pre-divider and loop output.
// R10 - Loop output is input divided by pre-divider then multiplied.
// R11 - The five-bit multiplier gives a factor of its value plus one.
// R12 - Pre-divider bit 15 enables its output, reset value one.
// R13 - Pre-divider ratio 0,1,2 divides by 1,2,3, reset value 2h.
// R14 - Software never programs pre-divider ratio 3h through 1Fh.
// R15 - Software holds loop reset at least 128 input periods.
// R16 - Software allows 2000 input periods of lock before multiply mode.
// R17 - In bypass, register changes are stored but not applied until
//       multiply mode is selected.
module mcmc_control (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic CPU_SEL,
   input wire logic CPU_WR,
   input wire logic [31:0] CPU_ADDR,
   input wire logic [31:0] CPU_WDATA,
   output logic CPU_ACK,
   input wire logic EMU_SEL,
   input wire logic EMU_WR,
   input wire logic [31:0] EMU_ADDR,
   input wire logic [31:0] EMU_WDATA,
   output logic EMU_ACK,
   output logic [31:0] RDATA,
   output logic LOOP_RESET,
   output logic LOOP_POWER_DOWN,
   output logic MULTIPLY_MODE_SELECT,
   output logic REF_FROM_LOOP,
   output logic PRE_DIVIDER_ENABLE,
   output logic [5:0] LOOP_FACTOR,
   output logic [5:0] PRE_DIVIDE_BY
);
   mcmc_steer_if st_if ();

   logic mode_q, mode_d;
   logic pwrdn_q, pwrdn_d;
   logic lrst_q, lrst_d;
   logic rsv7_q, rsv7_d;
   logic [1:0] rsv54_q, rsv54_d;
   logic [4:0] mult_q, mult_d;
   logic pre_en_q, pre_en_d;
   logic [4:0] pre_ratio_q, pre_ratio_d;
   logic cpu_ack_q, cpu_ack_d;
   logic emu_ack_q, emu_ack_d;
   logic [31:0] rdata_q, rdata_d;

   logic req;
   logic req_wr;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic [31:0] rd_mux;

   // core wins a tie; the emulator simply waits for its ack
   always_comb begin
      req = CPU_SEL | EMU_SEL; // R1
      req_wr = CPU_SEL ? CPU_WR : EMU_WR;
      req_addr = CPU_SEL ? CPU_ADDR : EMU_ADDR;
      req_wdata = CPU_SEL ? CPU_WDATA : EMU_WDATA;
   end

   // read image; reserved bits 7 and 5:4 are storage, the other reserved bits are constants
   always_comb begin
      rd_mux = 32'h00000000; // R3
      case (req_addr)
         mcmc_pkg::LOOP_CONTROL_ADDR: begin
            rd_mux[mcmc_pkg::CTL_MODE_BIT] = mode_q;
            rd_mux[mcmc_pkg::CTL_PWRDN_BIT] = pwrdn_q;
            rd_mux[mcmc_pkg::CTL_RESET_BIT] = lrst_q;
            rd_mux[mcmc_pkg::CTL_RSV54_LO +: 2] = rsv54_q;
            rd_mux[mcmc_pkg::CTL_RSV6_BIT] = mcmc_pkg::RSV6_VALUE; // R4
            rd_mux[mcmc_pkg::CTL_RSV7_BIT] = rsv7_q;
         end
         mcmc_pkg::LOOP_MULTIPLIER_ADDR: begin
            rd_mux[mcmc_pkg::MULT_LO +: mcmc_pkg::MULT_W] = mult_q;
         end
         mcmc_pkg::INPUT_PRE_DIVIDER_ADDR: begin
            rd_mux[mcmc_pkg::PRE_EN_BIT] = pre_en_q;
            rd_mux[mcmc_pkg::PRE_RATIO_LO +: mcmc_pkg::PRE_RATIO_W] =
               pre_ratio_q;
         end
         default: begin
            rd_mux = 32'h00000000; // unmapped reads zero
         end
      endcase
   end

   // register writes; unmapped writes are dropped
   always_comb begin
      mode_d = mode_q;
      pwrdn_d = pwrdn_q;
      lrst_d = lrst_q;
      rsv7_d = rsv7_q;
      rsv54_d = rsv54_q;
      mult_d = mult_q;
      pre_en_d = pre_en_q;
      pre_ratio_d = pre_ratio_q;
      if (req && req_wr) begin
         case (req_addr)
            mcmc_pkg::LOOP_CONTROL_ADDR: begin
               mode_d = req_wdata[mcmc_pkg::CTL_MODE_BIT]; // R8 R9
               pwrdn_d = req_wdata[mcmc_pkg::CTL_PWRDN_BIT]; // R7
               lrst_d = req_wdata[mcmc_pkg::CTL_RESET_BIT]; // R6
               // kept as storage so a read returns what was written
               rsv7_d = req_wdata[mcmc_pkg::CTL_RSV7_BIT];
               rsv54_d = req_wdata[mcmc_pkg::CTL_RSV54_LO +: 2];
            end
            mcmc_pkg::LOOP_MULTIPLIER_ADDR: begin
               mult_d = req_wdata[mcmc_pkg::MULT_LO +: mcmc_pkg::MULT_W];
            end
            mcmc_pkg::INPUT_PRE_DIVIDER_ADDR: begin
               pre_en_d = req_wdata[mcmc_pkg::PRE_EN_BIT]; // R12
               // reserved ratios are the writer's problem, stored as is
               pre_ratio_d =
                  req_wdata[mcmc_pkg::PRE_RATIO_LO +: mcmc_pkg::PRE_RATIO_W];
            end
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
   end

   // answer one cycle after the request is taken
   always_comb begin
      cpu_ack_d = CPU_SEL; // R1
      emu_ack_d = EMU_SEL & ~CPU_SEL;
      rdata_d = req ? rd_mux : rdata_q;
   end

   // all state of this block
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_q <= mcmc_pkg::RST_MODE; // R8
         pwrdn_q <= mcmc_pkg::RST_PWRDN; // R7
         lrst_q <= mcmc_pkg::RST_LOOP_RESET; // R6
         rsv7_q <= mcmc_pkg::RST_RSV7;
         rsv54_q <= mcmc_pkg::RST_RSV54;
         mult_q <= mcmc_pkg::RST_MULT;
         pre_en_q <= mcmc_pkg::RST_PRE_EN; // R12
         pre_ratio_q <= mcmc_pkg::RST_PRE_RATIO; // R13
         cpu_ack_q <= 1'b0;
         emu_ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         mode_q <= mode_d;
         pwrdn_q <= pwrdn_d;
         lrst_q <= lrst_d;
         rsv7_q <= rsv7_d;
         rsv54_q <= rsv54_d;
         mult_q <= mult_d;
         pre_en_q <= pre_en_d;
         pre_ratio_q <= pre_ratio_d;
         cpu_ack_q <= cpu_ack_d;
         emu_ack_q <= emu_ack_d;
         rdata_q <= rdata_d;
      end
   end

   // stored settings feed the reference path steering
   assign st_if.mode = mode_q;
   assign st_if.mult = mult_q;
   assign st_if.pre_en = pre_en_q;
   assign st_if.pre_ratio = pre_ratio_q;

   mcmc_steer u_steer (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .st(st_if.steer)
   );

   // outputs, each straight from a flop
   assign CPU_ACK = cpu_ack_q;
   assign EMU_ACK = emu_ack_q;
   assign RDATA = rdata_q;
   assign LOOP_RESET = lrst_q; // R6
   assign LOOP_POWER_DOWN = pwrdn_q; // R7
   assign MULTIPLY_MODE_SELECT = mode_q;
   assign REF_FROM_LOOP = st_if.src_loop; // R9
   assign PRE_DIVIDER_ENABLE = st_if.pre_out_en; // R12
   assign LOOP_FACTOR = st_if.factor; // R10
   assign PRE_DIVIDE_BY = st_if.divisor; // R10

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   a_port_only_ack: assert property ((CPU_ACK | EMU_ACK) |-> // R1
      $past(CPU_SEL) | $past(EMU_SEL))
      else $error("ack without a core or emulator request");
   a_ctrl_bit_six: assert property (CPU_SEL && !CPU_WR && // R4
      CPU_ADDR == mcmc_pkg::LOOP_CONTROL_ADDR |=> RDATA[6] &&
      RDATA[31:8] == 24'h000000 && !RDATA[2])
      else $error("control readback reserved bits wrong");
   a_rsv_pre_zero: assert property (CPU_SEL && !CPU_WR && // R3
      CPU_ADDR == mcmc_pkg::INPUT_PRE_DIVIDER_ADDR |=>
      RDATA[31:16] == 16'h0000 && RDATA[14:5] == 10'h000)
      else $error("pre-divider reserved bits not zero");
   a_reset_bit_write: assert property (CPU_SEL && CPU_WR && // R6
      CPU_ADDR == mcmc_pkg::LOOP_CONTROL_ADDR |=>
      LOOP_RESET == $past(CPU_WDATA[3]) &&
      LOOP_POWER_DOWN == $past(CPU_WDATA[1]))
      else $error("loop reset or power down not updated");
   a_mode_path: assert property (MULTIPLY_MODE_SELECT |=> // R9
      REF_FROM_LOOP)
      else $error("multiply mode did not route loop output");
   a_pre_divide: assert property (MULTIPLY_MODE_SELECT |=> // R13
      PRE_DIVIDE_BY == {1'b0, $past(pre_ratio_q)} + 6'h01)
      else $error("pre-divide factor not ratio plus one");
   a_pre_enable: assert property (MULTIPLY_MODE_SELECT |=> // R12
      PRE_DIVIDER_ENABLE == $past(pre_en_q))
      else $error("pre-divider enable not applied");
   a_emu_waits: assert property (CPU_SEL && EMU_SEL |=> !EMU_ACK) // R1
      else $error("emulator served during core access");

   c_cpu_write: cover property (CPU_SEL && CPU_WR ##1 CPU_ACK);
   c_emu_read: cover property (EMU_SEL && !CPU_SEL ##1 EMU_ACK);
   c_release: cover property ($fell(LOOP_RESET) ##[1:20]
      MULTIPLY_MODE_SELECT);
endmodule : mcmc_control

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g));
module tb;
   localparam int LIMIT = 4000; // covers the 128 and 2000 cycle waits
   logic CORE_CLK, SYS_RST;
   logic CPU_SEL, CPU_WR, EMU_SEL, EMU_WR, CPU_ACK, EMU_ACK;
   logic [31:0] CPU_ADDR, CPU_WDATA, EMU_ADDR, EMU_WDATA, RDATA;
   logic LOOP_RESET, LOOP_POWER_DOWN, MULTIPLY_MODE_SELECT;
   logic REF_FROM_LOOP, PRE_DIVIDER_ENABLE;
   logic [5:0] LOOP_FACTOR, PRE_DIVIDE_BY;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   logic [4:0] mv [6] = '{5'h00, 5'h0e, 5'h13, 5'h18, 5'h1d, 5'h1f};

   mcmc_control u_mcmc_control (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
      .CPU_SEL(CPU_SEL), .CPU_WR(CPU_WR), .CPU_ADDR(CPU_ADDR),
      .CPU_WDATA(CPU_WDATA), .CPU_ACK(CPU_ACK), .EMU_SEL(EMU_SEL),
      .EMU_WR(EMU_WR), .EMU_ADDR(EMU_ADDR), .EMU_WDATA(EMU_WDATA),
      .EMU_ACK(EMU_ACK), .RDATA(RDATA), .LOOP_RESET(LOOP_RESET),
      .LOOP_POWER_DOWN(LOOP_POWER_DOWN),
      .MULTIPLY_MODE_SELECT(MULTIPLY_MODE_SELECT),
      .REF_FROM_LOOP(REF_FROM_LOOP),
      .PRE_DIVIDER_ENABLE(PRE_DIVIDER_ENABLE),
      .LOOP_FACTOR(LOOP_FACTOR), .PRE_DIVIDE_BY(PRE_DIVIDE_BY));

   // 25 MHz core clock
   initial begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end

   // hang guard, counted as a mismatch
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // one access on the core or emulator port; ack must follow in one cycle
   task automatic access(input logic emu, input logic wr,
                         input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
      int n;
      n = 0;
      if (emu) begin
         EMU_SEL = 1'b1; EMU_WR = wr; EMU_ADDR = a; EMU_WDATA = d;
      end else begin
         CPU_SEL = 1'b1; CPU_WR = wr; CPU_ADDR = a; CPU_WDATA = d;
      end
      do begin
         @(posedge CORE_CLK);
         @(negedge CORE_CLK);
         n++;
      end while ((emu ? EMU_ACK : CPU_ACK) !== 1'b1 && n < 8);
      `CHK("ack_delay", 1, n)
      rd = RDATA;
      // released lines show the inverse so stale values cannot pass
      if (emu) begin
         EMU_SEL = 1'b0; EMU_ADDR = ~a; EMU_WDATA = ~d;
      end else begin
         CPU_SEL = 1'b0; CPU_ADDR = ~a; CPU_WDATA = ~d;
      end
      // idle edge so a following call never re-raises select in this step
      @(negedge CORE_CLK);
   endtask : access

   task automatic wr(input logic emu, input logic [31:0] a,
                     input logic [31:0] d);
      logic [31:0] r;
      access(emu, 1'b1, a, d, r);
   endtask : wr

   task automatic rd_chk(input logic emu, input logic [31:0] a,
                         input logic [31:0] e);
      logic [31:0] r;
      access(emu, 1'b0, a, 32'h0, r);
      `CHK("rdata", e, r)
   endtask : rd_chk

   // let the register update and the steering lag land
   task automatic settle();
      repeat (2) @(negedge CORE_CLK);
   endtask : settle

   task automatic outs(input logic [5:0] f, input logic [5:0] dv,
                       input logic en, input logic src);
      `CHK("loop_factor", f, LOOP_FACTOR)
      `CHK("pre_divide_by", dv, PRE_DIVIDE_BY)
      `CHK("pre_divider_enable", en, PRE_DIVIDER_ENABLE)
      `CHK("ref_from_loop", src, REF_FROM_LOOP)
      `CHK("mode", src, MULTIPLY_MODE_SELECT)
   endtask : outs

   initial begin
      SYS_RST = 1'b1;
      CPU_SEL = 1'b0; CPU_WR = 1'b0; CPU_ADDR = 32'h0; CPU_WDATA = 32'h0;
      EMU_SEL = 1'b0; EMU_WR = 1'b0; EMU_ADDR = 32'h0; EMU_WDATA = 32'h0;
      repeat (12) @(negedge CORE_CLK);
      SYS_RST = 1'b0;
      // values after reset
      `CHK("loop_reset", 1, LOOP_RESET)
      `CHK("power_down", 0, LOOP_POWER_DOWN)
      outs(6'h01, 6'h03, 1'b1, 1'b0);
      rd_chk(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h48);
      rd_chk(1'b1, mcmc_pkg::LOOP_MULTIPLIER_ADDR, 32'h0);
      rd_chk(1'b0, mcmc_pkg::INPUT_PRE_DIVIDER_ADDR, 32'h8002);
      // read-only reserved fields ignore ones, bit 6 ignores a zero
      wr(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'hffffff06);
      rd_chk(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h42);
      `CHK("power_down", 1, LOOP_POWER_DOWN)
      `CHK("loop_reset", 0, LOOP_RESET)
      wr(1'b1, mcmc_pkg::LOOP_MULTIPLIER_ADDR, 32'hfffffff3);
      rd_chk(1'b1, mcmc_pkg::LOOP_MULTIPLIER_ADDR, 32'h13);
      wr(1'b0, mcmc_pkg::INPUT_PRE_DIVIDER_ADDR, 32'hffff7fe1);
      rd_chk(1'b0, mcmc_pkg::INPUT_PRE_DIVIDER_ADDR, 32'h1);
      settle();
      outs(6'h01, 6'h03, 1'b1, 1'b0);
      // unmapped place: software never writes it, reads zero, still answered
      rd_chk(1'b0, 32'h029a0104, 32'h0);
      // both ports at once: core taken first, emulator held, served next
      CPU_SEL = 1'b1;
      CPU_WR = 1'b0;
      CPU_ADDR = mcmc_pkg::LOOP_CONTROL_ADDR;
      EMU_SEL = 1'b1;
      EMU_WR = 1'b0;
      EMU_ADDR = mcmc_pkg::LOOP_MULTIPLIER_ADDR;
      @(negedge CORE_CLK);
      `CHK("cpu_ack", 1, CPU_ACK)
      `CHK("emu_ack", 0, EMU_ACK)
      `CHK("rdata", 32'h42, RDATA)
      CPU_SEL = 1'b0;
      @(negedge CORE_CLK);
      `CHK("cpu_ack", 0, CPU_ACK)
      `CHK("emu_ack", 1, EMU_ACK)
      `CHK("rdata", 32'h13, RDATA)
      EMU_SEL = 1'b0;
      @(negedge CORE_CLK);
      // loop start-up: reset, release, lock, then multiply mode
      wr(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h08);
      repeat (mcmc_pkg::RESET_TIME_CYC) @(negedge CORE_CLK);
      wr(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h00);
      repeat (mcmc_pkg::LOCK_TIME_CYC) @(negedge CORE_CLK);
      wr(1'b1, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h01);
      `CHK("mode", 1, MULTIPLY_MODE_SELECT)
      @(negedge CORE_CLK);
      outs(6'h14, 6'h02, 1'b0, 1'b1);
      rd_chk(1'b1, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h41);
      // every listed multiplier code, back to back ports
      foreach (mv[i]) begin
         wr(i[0], mcmc_pkg::LOOP_MULTIPLIER_ADDR, {27'h0, mv[i]});
         settle();
         `CHK("loop_factor", mv[i] + 6'h01, LOOP_FACTOR)
      end
      // every legal ratio with the divider enabled
      for (int k = 0; k < 3; k++) begin
         wr(k[0], mcmc_pkg::INPUT_PRE_DIVIDER_ADDR, 32'h8000 | k);
         settle();
         outs(6'h20, 6'(k + 1), 1'b1, 1'b1);
      end
      // back to bypass: new settings stored but not applied
      wr(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h00);
      settle();
      outs(6'h20, 6'h03, 1'b1, 1'b0);
      wr(1'b1, mcmc_pkg::LOOP_MULTIPLIER_ADDR, 32'h04);
      wr(1'b0, mcmc_pkg::INPUT_PRE_DIVIDER_ADDR, 32'h0);
      settle();
      outs(6'h20, 6'h03, 1'b1, 1'b0);
      rd_chk(1'b1, mcmc_pkg::LOOP_MULTIPLIER_ADDR, 32'h04);
      wr(1'b0, mcmc_pkg::LOOP_CONTROL_ADDR, 32'h01);
      settle();
      outs(6'h05, 6'h01, 1'b0, 1'b1);
      finish_test();
   end
endmodule : tb
